// file: inc/ppp_pkg.sv
// shared constants for the parallel nvm programming port
package ppp_pkg;
	// =========================================
	// clock and timing
	localparam int CLK_NS = 20; // ref_clk period
	localparam int T_WR_MIN_US = 3700; // 3.7 ms self-timed write
	localparam int T_WR_MAX_US = 4500; // 4.5 ms upper bound
	localparam int T_CE_MIN_US = 7500; // 7.5 ms chip erase
	localparam int T_CE_MAX_US = 9000; // 9 ms upper bound
	localparam int T_RB_MAX_US = 1; // strobe fall to busy, at most
	localparam int T_SU_NS = 67; // data/control setup and hold
	localparam int T_PW_NS = 150; // strobe pulse width
	// least times round up, longest round down
	localparam int WR_CYC = (T_WR_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int CE_CYC = (T_CE_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int RB_MAX_CYC = T_RB_MAX_US * 1000 / CLK_NS;
	localparam int SU_CYC = (T_SU_NS + CLK_NS - 1) / CLK_NS;
	localparam int PW_CYC = (T_PW_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCK_HALF_CYC = 4; // more than 3 device clocks
	// =========================================
	// parallel commands and action selects
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_FL_WR = 8'h10;
	localparam logic [7:0] CMD_EE_WR = 8'h11;
	localparam logic [7:0] CMD_LOCK_WR = 8'h20;
	localparam logic [7:0] CMD_FUSE_WR = 8'h40;
	localparam logic [7:0] CMD_RD_FL = 8'h04;
	localparam logic [7:0] CMD_RD_SIG = 8'h08;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	// =========================================
	// serial instruction bytes
	localparam logic [7:0] SER_PE1 = 8'hac;
	localparam logic [7:0] SER_PE2 = 8'h53;
	localparam logic [2:0] SER_CE2 = 3'h4;
	localparam logic [7:0] SER_RD_EE = 8'ha0;
	localparam logic [7:0] SER_WR_EE = 8'hc0;
	// =========================================
	// reset values
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [7:0] FUSE_RST = 8'hff;
	localparam logic [7:0] LOCK_RST = 8'hff;
	// =========================================
	// host register map and fields
	localparam logic [7:0] HR_PINS = 8'h00;
	localparam logic [7:0] HR_GO = 8'h04;
	localparam logic [7:0] HR_STAT = 8'h08;
	localparam logic [7:0] HR_SPI = 8'h0c;
	localparam int PIN_BS1 = 2;
	localparam int PIN_BS2 = 3;
	localparam int PIN_SRST = 4;
	localparam int PIN_DAT = 8;
	localparam logic [31:0] PINS_RST = 32'h0000_0010;
	localparam logic [1:0] OP_LOAD = 2'h0;
	localparam logic [1:0] OP_PAGE = 2'h1;
	localparam logic [1:0] OP_PROG = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
endpackage

// file: inc/ppp_if.sv
// pins between the programmer and the programmed device
`timescale 1ns/10ps
interface ppp_if;
	logic action_select_high; // action select, upper bit
	logic action_select_low; // action select, lower bit
	logic byte_select_primary; // low/high byte select
	logic byte_select_secondary; // fuse bank select
	logic load_strobe; // rising edge loads
	logic page_latch_strobe; // rising edge latches data
	logic prog_strobe_n; // falling edge starts a write
	logic out_drive_n; // low asks the device to drive data
	logic ready_busy_flag; // low while self-timed op runs
	logic ser_reset_n; // low selects serial mode
	logic sck; // serial clock
	logic mosi; // serial data in to device
	logic miso; // serial data out of device
	logic [7:0] h_data; // host drive value
	logic h_data_oe; // host drives the bus
	logic [7:0] d_data; // device drive value
	logic d_data_oe; // device drives the bus
	logic [7:0] data; // resolved bus, pulled high when idle
	assign data = d_data_oe ? d_data : (h_data_oe ? h_data : 8'hff);
	modport dev (
		input action_select_high, action_select_low,
		input byte_select_primary, byte_select_secondary,
		input load_strobe, page_latch_strobe, prog_strobe_n,
		input out_drive_n, ser_reset_n, sck, mosi, data,
		output ready_busy_flag, miso, d_data, d_data_oe
	);
	modport host (
		output action_select_high, action_select_low,
		output byte_select_primary, byte_select_secondary,
		output load_strobe, page_latch_strobe, prog_strobe_n,
		output out_drive_n, ser_reset_n, sck, mosi, h_data, h_data_oe,
		input ready_busy_flag, miso, data
	);
endinterface

// file: rtl/ppp_busy_timer.sv
// self-timed write and erase duration counter
`timescale 1ns/10ps
module ppp_busy_timer #(
	parameter int WR_CYC = ppp_pkg::WR_CYC,
	parameter int CE_CYC = ppp_pkg::CE_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// control
	input wire logic start,
	input wire logic erase,
	// status
	output logic busy
);
	// =========================================
	// counter
	logic [31:0] cnt_q; // cycles left, wide enough for any default
	// a start while busy is dropped, the callers gate it anyway
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cnt_q <= 32'h0;
		end else if (start && cnt_q == 32'h0) begin
			cnt_q <= erase ? 32'(CE_CYC) : 32'(WR_CYC);
		end else if (cnt_q != 32'h0) begin
			cnt_q <= cnt_q - 32'h1;
		end
	end
	assign busy = (cnt_q != 32'h0);
endmodule

// file: rtl/ppp_device.sv
// device end: parallel programming of fuses, locks, memories; serial eeprom writes and chip erase
//
// Summary of operation
// - action select 10 loads a command
// - command 00 is no-op, ends writes
// - eeprom: command, addresses, data, latch, repeat
// - page latch strobe writes the eeprom byte, program strobe only holds busy low
// - command 40 writes fuse low or high byte
// - command 20 programs lock bits (zeros)
// - only chip erase unprograms lock bits
// - command 04 reads fuse low/high, lock
// - command 08 reads identification bytes 0-2
// - command 08 with primary high reads calibration
// - writes keep busy 3.7 to 4.5 ms
// - chip erase keeps busy 7.5 to 9 ms
// - busy goes low within 1 us
// - serial writes and erase need programming enable first, reads do not
// - serial link: clock, data in, out
// - serial eeprom write erases location first
// - chip erase fills both memories with ff
// - programmer keeps a valid device clock
// - action select 01 loads data byte
// - action select 00 loads address byte
// - serial clock phases exceed 2 or 3 clocks
`timescale 1ns/10ps
module ppp_device #(
	parameter int EE_AW = 9, // eeprom byte address width
	parameter int FL_AW = 12, // flash word address width, >= EE_AW
	parameter int WR_CYC = ppp_pkg::WR_CYC,
	parameter int CE_CYC = ppp_pkg::CE_CYC,
	parameter logic [7:0] SIG0 = 8'h5a, // arbitrary identification
	parameter logic [7:0] SIG1 = 8'h3c, // arbitrary identification
	parameter logic [7:0] SIG2 = 8'h0f, // arbitrary identification
	parameter logic [7:0] CALIB = 8'h80 // calibration byte
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// programming pins
	ppp_if.dev pins,
	// user side status
	output logic [7:0] fuse_low,
	output logic [7:0] fuse_high,
	output logic [7:0] lock_bits,
	output logic ser_enabled
);
	// =========================================
	// pin sampling and edge detect
	logic ls_q, pl_q, wr_q, sck_q; // previous pin levels
	logic par_mode; // reset pin high: parallel port active
	logic ls_rise, pl_rise, wr_fall, s_rise, s_fall;
	// inputs are synchronous to ref_clk, one flop finds edges
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ls_q <= 1'b0;
			pl_q <= 1'b0;
			wr_q <= 1'b1;
			sck_q <= 1'b0;
		end else begin
			ls_q <= pins.load_strobe;
			pl_q <= pins.page_latch_strobe;
			wr_q <= pins.prog_strobe_n;
			sck_q <= pins.sck;
		end
	end
	assign par_mode = pins.ser_reset_n;
	assign ls_rise = par_mode & pins.load_strobe & ~ls_q;
	assign pl_rise = par_mode & pins.page_latch_strobe & ~pl_q;
	assign wr_fall = par_mode & ~pins.prog_strobe_n & wr_q;
	assign s_rise = ~par_mode & pins.sck & ~sck_q;
	assign s_fall = ~par_mode & ~pins.sck & sck_q;

	// =========================================
	// command, address and data latches
	logic [7:0] cmd_q, addr_lo_q, addr_hi_q, dat_lo_q, dat_hi_q;
	logic [15:0] addr_w; // full parallel address
	logic [1:0] act; // current action select
	assign act = {pins.action_select_high, pins.action_select_low};
	assign addr_w = {addr_hi_q, addr_lo_q};
	// every parallel-mode load strobe rise captures one byte by action select, except select 11
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cmd_q <= ppp_pkg::CMD_NOP;
			addr_lo_q <= 8'h00;
			addr_hi_q <= 8'h00;
			dat_lo_q <= 8'h00;
			dat_hi_q <= 8'h00;
		end else if (ls_rise) begin
			unique case (act)
				ppp_pkg::ACT_CMD: begin
					// a nop command clears the write state too
					cmd_q <= pins.data;
				end
				ppp_pkg::ACT_DATA: begin
					if (pins.byte_select_primary) begin
						dat_hi_q <= pins.data;
					end else begin
						dat_lo_q <= pins.data;
					end
				end
				ppp_pkg::ACT_ADDR: begin
					if (pins.byte_select_primary) begin
						addr_hi_q <= pins.data;
					end else begin
						addr_lo_q <= pins.data;
					end
				end
				default: begin
					// 11 is idle, nothing is loaded
				end
			endcase
		end
	end

	// =========================================
	// serial shifter
	logic [31:0] sr_q; // received bits, newest at lsb
	logic [4:0] bit_q; // bit count within the 4-byte frame
	logic [7:0] so_q; // outgoing byte, msb on the pin
	logic en_q; // programming enable seen
	logic [31:0] s_word; // shift value including this bit
	logic [4:0] s_next;
	logic s_done; // 32nd bit of an instruction arrived
	logic s_pe, s_ce, s_wr; // decoded serial instructions
	logic busy; // self-timed operation running
	assign s_word = {sr_q[30:0], pins.mosi};
	assign s_next = bit_q + 5'h1;
	assign s_done = s_rise && bit_q == 5'h1f;
	assign s_pe = s_word[31:24] == ppp_pkg::SER_PE1
		&& s_word[23:16] == ppp_pkg::SER_PE2;
	assign s_ce = en_q && !busy && s_word[31:24] == ppp_pkg::SER_PE1
		&& s_word[23:21] == ppp_pkg::SER_CE2;
	assign s_wr = en_q && !busy
		&& s_word[31:24] == ppp_pkg::SER_WR_EE;
	logic [7:0] ee_rd; // eeprom read for the serial return byte
	logic [7:0] ee_mem [2**EE_AW]; // eeprom array
	logic [15:0] fl_mem [2**FL_AW]; // flash array
	assign ee_rd = ee_mem[s_word[EE_AW-1:0]];
	// data in on sck rise, data out moves on sck fall
	always_ff @(posedge ref_clk) begin
		if (!rstn || par_mode) begin
			sr_q <= 32'h0;
			bit_q <= 5'h0;
			so_q <= 8'h00;
			en_q <= 1'b0; // leaving serial mode drops enable
		end else begin
			if (s_rise) begin
				sr_q <= s_word;
				bit_q <= s_next;
				if (s_next == 5'h10) begin
					so_q <= s_word[7:0]; // echo byte two
				end else if (s_next == 5'h18
					&& s_word[23:16] == ppp_pkg::SER_RD_EE) begin
					// polling during a write returns ff
					so_q <= busy ? ppp_pkg::ERASED : ee_rd;
				end
			end else if (s_fall && bit_q[2:0] != 3'h0) begin
				so_q <= {so_q[6:0], 1'b0};
			end
			if (s_done && s_pe) begin
				en_q <= 1'b1;
			end
		end
	end
	assign pins.miso = so_q[7];

	// =========================================
	// self-timed writes and chip erase
	logic par_go, par_ce, start, erase;
	logic [FL_AW-1:0] ce_ptr_q; // location being erased
	logic ce_act_q; // erase sweep running
	// only write and erase commands start the timer, nop leaves nothing armed
	assign par_go = wr_fall && !busy && (cmd_q == ppp_pkg::CMD_FL_WR
		|| cmd_q == ppp_pkg::CMD_EE_WR || cmd_q == ppp_pkg::CMD_FUSE_WR
		|| cmd_q == ppp_pkg::CMD_LOCK_WR);
	assign par_ce = wr_fall && !busy && cmd_q == ppp_pkg::CMD_ERASE;
	assign erase = par_ce | (s_done & s_ce);
	assign start = par_go | erase | (s_done & s_wr);
	// busy rises on the edge after the strobe fall, far under 1 us
	ppp_busy_timer #(
		.WR_CYC(WR_CYC),
		.CE_CYC(CE_CYC)
	) u_timer (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.start(start),
		.erase(erase),
		.busy(busy)
	);
	assign pins.ready_busy_flag = ~busy;

	// erase sweeps one location per clock, well inside the busy time
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ce_act_q <= 1'b0;
			ce_ptr_q <= '0;
		end else if (erase) begin
			ce_act_q <= 1'b1;
			ce_ptr_q <= '0;
		end else if (ce_act_q) begin
			ce_ptr_q <= ce_ptr_q + 1'b1;
			ce_act_q <= ce_ptr_q != '1;
		end
	end

	// =========================================
	// memory arrays
	// parallel eeprom data only clears bits, no auto erase there
	always_ff @(posedge ref_clk) begin
		if (ce_act_q) begin
			ee_mem[ce_ptr_q[EE_AW-1:0]] <= ppp_pkg::ERASED;
		end else if (pl_rise && !busy
			&& cmd_q == ppp_pkg::CMD_EE_WR) begin
			ee_mem[addr_w[EE_AW-1:0]] <=
				ee_mem[addr_w[EE_AW-1:0]] & dat_lo_q;
		end else if (s_done && s_wr) begin
			// serial write replaces the byte: erase then write
			ee_mem[s_word[8 +: EE_AW]] <= s_word[7:0];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (ce_act_q) begin
			fl_mem[ce_ptr_q] <= {ppp_pkg::ERASED, ppp_pkg::ERASED};
		end else if (pl_rise && !busy
			&& cmd_q == ppp_pkg::CMD_FL_WR) begin
			fl_mem[addr_w[FL_AW-1:0]] <=
				fl_mem[addr_w[FL_AW-1:0]] & {dat_hi_q, dat_lo_q};
		end
	end

	// =========================================
	// fuses and lock bits
	logic [7:0] fuse_lo_q, fuse_hi_q, lock_q;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			fuse_lo_q <= ppp_pkg::FUSE_RST;
			fuse_hi_q <= ppp_pkg::FUSE_RST;
			lock_q <= ppp_pkg::LOCK_RST;
		end else if (erase) begin
			lock_q <= ppp_pkg::LOCK_RST;
		end else if (par_go && cmd_q == ppp_pkg::CMD_LOCK_WR) begin
			lock_q <= lock_q & dat_lo_q;
		end else if (par_go && cmd_q == ppp_pkg::CMD_FUSE_WR) begin
			if (pins.byte_select_primary && !pins.byte_select_secondary) begin
				fuse_hi_q <= dat_lo_q;
			end else if (!pins.byte_select_primary) begin
				fuse_lo_q <= dat_lo_q;
			end
		end
	end
	assign fuse_low = fuse_lo_q;
	assign fuse_high = fuse_hi_q;
	assign lock_bits = lock_q;
	assign ser_enabled = en_q;

	// =========================================
	// read back onto the data bus
	function automatic logic [7:0] sig_byte(input logic [7:0] a);
		unique case (a)
			8'h00: sig_byte = SIG0;
			8'h01: sig_byte = SIG1;
			8'h02: sig_byte = SIG2;
			default: sig_byte = 8'h00;
		endcase
	endfunction
	logic [7:0] rd_d, rd_q;
	logic oe_d, oe_q;
	always_comb begin
		rd_d = 8'h00;
		oe_d = 1'b0;
		if (par_mode && !pins.out_drive_n) begin
			if (cmd_q == ppp_pkg::CMD_RD_FL) begin
				oe_d = 1'b1;
				unique case ({pins.byte_select_secondary,
					pins.byte_select_primary})
					2'h0: rd_d = fuse_lo_q;
					2'h3: rd_d = fuse_hi_q;
					2'h1: rd_d = lock_q;
					default: rd_d = ppp_pkg::ERASED;
				endcase
			end else if (cmd_q == ppp_pkg::CMD_RD_SIG) begin
				oe_d = 1'b1;
				if (pins.byte_select_primary) begin
					rd_d = CALIB;
				end else begin
					rd_d = sig_byte(addr_lo_q);
				end
			end
		end
	end
	// raising out_drive_n releases the bus one clock later
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rd_q <= 8'h00;
			oe_q <= 1'b0;
		end else begin
			rd_q <= rd_d;
			oe_q <= oe_d;
		end
	end
	assign pins.d_data = rd_q;
	assign pins.d_data_oe = oe_q;
endmodule

// file: rtl/ppp_host.sv
// host end: programmer sequencing pins from a simple register port
`timescale 1ns/10ps
module ppp_host #(
	parameter int SU = ppp_pkg::SU_CYC, // setup and hold clocks
	parameter int PW = ppp_pkg::PW_CYC, // strobe width clocks
	parameter int SH = ppp_pkg::SCK_HALF_CYC // sck half period
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// programming pins
	ppp_if.host pins
);
	// =========================================
	// pin level register
	typedef enum logic [1:0] {
		S_IDLE = 2'h0, S_SETUP = 2'h1, S_PULSE = 2'h3, S_HOLD = 2'h2
	} ppp_st_e;
	ppp_st_e st_q;
	logic [31:0] pins_q; // static pin levels and data byte
	logic [1:0] op_q; // running operation
	logic [7:0] cnt_q; // phase counter
	logic [7:0] rdat_q; // last byte read from the device
	logic go; // write to the go register while idle
	assign go = wr && addr == ppp_pkg::HR_GO && st_q == S_IDLE;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pins_q <= ppp_pkg::PINS_RST;
		end else if (wr && addr == ppp_pkg::HR_PINS) begin
			pins_q <= wdata;
		end
	end
	assign pins.action_select_low = pins_q[0];
	assign pins.action_select_high = pins_q[1];
	assign pins.byte_select_primary = pins_q[ppp_pkg::PIN_BS1];
	assign pins.byte_select_secondary = pins_q[ppp_pkg::PIN_BS2];
	assign pins.ser_reset_n = pins_q[ppp_pkg::PIN_SRST];

	// =========================================
	// strobe sequencer: setup, pulse, hold
	// a go while a sequence runs is ignored
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st_q <= S_IDLE;
			op_q <= ppp_pkg::OP_LOAD;
			cnt_q <= 8'h0;
			rdat_q <= 8'h00;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					if (go) begin
						op_q <= wdata[1:0];
						cnt_q <= 8'(SU - 1);
						st_q <= S_SETUP;
					end
				end
				S_SETUP: begin
					cnt_q <= cnt_q - 8'h1;
					if (cnt_q == 8'h0) begin
						cnt_q <= 8'(PW - 1);
						st_q <= S_PULSE;
					end
				end
				S_PULSE: begin
					cnt_q <= cnt_q - 8'h1;
					if (cnt_q == 8'h0) begin
						if (op_q == ppp_pkg::OP_READ) begin
							rdat_q <= pins.data;
						end
						cnt_q <= 8'(SU - 1);
						st_q <= S_HOLD;
					end
				end
				S_HOLD: begin
					cnt_q <= cnt_q - 8'h1;
					if (cnt_q == 8'h0) begin
						st_q <= S_IDLE;
					end
				end
			endcase
		end
	end
	assign pins.load_strobe = st_q == S_PULSE && op_q == ppp_pkg::OP_LOAD;
	assign pins.page_latch_strobe = st_q == S_PULSE
		&& op_q == ppp_pkg::OP_PAGE;
	assign pins.prog_strobe_n = !(st_q == S_PULSE
		&& op_q == ppp_pkg::OP_PROG);
	assign pins.out_drive_n = !(st_q == S_PULSE && op_q == ppp_pkg::OP_READ);
	assign pins.h_data = pins_q[ppp_pkg::PIN_DAT +: 8];
	assign pins.h_data_oe = st_q != S_IDLE && op_q == ppp_pkg::OP_LOAD;

	// =========================================
	// serial master, slow enough for any device clock used here
	logic [31:0] tx_q, rx_q;
	logic [5:0] nb_q; // falling edges left in the frame
	logic [7:0] hc_q; // half period counter
	logic sck_q;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tx_q <= 32'h0;
			rx_q <= 32'h0;
			nb_q <= 6'h0;
			hc_q <= 8'h0;
			sck_q <= 1'b0;
		end else if (nb_q == 6'h0) begin
			if (wr && addr == ppp_pkg::HR_SPI) begin
				tx_q <= wdata;
				nb_q <= 6'h20;
				hc_q <= 8'(SH - 1);
			end
		end else if (hc_q != 8'h0) begin
			hc_q <= hc_q - 8'h1;
		end else begin
			hc_q <= 8'(SH - 1);
			sck_q <= ~sck_q;
			if (!sck_q) begin
				rx_q <= {rx_q[30:0], pins.miso};
			end else begin
				tx_q <= {tx_q[30:0], 1'b0};
				nb_q <= nb_q - 6'h1;
			end
		end
	end
	assign pins.sck = sck_q;
	assign pins.mosi = tx_q[31];

	// =========================================
	// read data, one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rdata <= 32'h0;
		end else if (rd) begin
			unique case (addr)
				ppp_pkg::HR_PINS: rdata <= pins_q;
				ppp_pkg::HR_STAT: rdata <= {16'h0, rdat_q, 5'h0,
					nb_q != 6'h0, pins.ready_busy_flag, st_q != S_IDLE};
				ppp_pkg::HR_SPI: rdata <= rx_q;
				default: rdata <= 32'h0;
			endcase
		end else begin
			rdata <= 32'h0;
		end
	end
endmodule

// file: dv/ppp_sva.sv
// pin-level assertions between programmer and programmed device
`timescale 1ns/10ps
module ppp_sva #(
	parameter int WR_CYC = 20,
	parameter int CE_CYC = 80,
	parameter logic [7:0] SIG0 = 8'h5a, // arbitrary identification
	parameter logic [7:0] SIG1 = 8'h3c, // arbitrary identification
	parameter logic [7:0] SIG2 = 8'h0f, // arbitrary identification
	parameter logic [7:0] CALIB = 8'h80
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// programmer pins
	input wire logic action_select_high,
	input wire logic action_select_low,
	input wire logic byte_select_primary,
	input wire logic load_strobe,
	input wire logic prog_strobe_n,
	input wire logic out_drive_n,
	input wire logic ser_reset_n,
	// device pins
	input wire logic ready_busy_flag,
	input wire logic [7:0] d_data,
	input wire logic d_data_oe,
	input wire logic [7:0] data
);
	logic [7:0] cmd_q; // last command loaded
	logic [7:0] alo_q; // last address low byte
	logic ls_q; // load strobe one cycle ago
	int low_q; // cycles ready has stayed low
	logic wcmd; // command that starts a timed write or chip erase
	logic [7:0] sig; // expected identification byte
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// =====================================
	// shadow of the command and address loads
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cmd_q <= 8'h00;
			alo_q <= 8'h00;
			ls_q <= 1'b0;
		end else begin
			ls_q <= load_strobe;
			// only the rising level of the strobe captures
			if (load_strobe && !ls_q && ser_reset_n) begin
				if ({action_select_high, action_select_low} == 2'h2)
					cmd_q <= data;
				if ({action_select_high, action_select_low} == 2'h0 &&
					!byte_select_primary)
					alo_q <= data;
			end
		end
	end
	// counts the busy window so its length can be judged at the end
	always_ff @(posedge ref_clk) begin
		if (!rstn || ready_busy_flag)
			low_q <= 0;
		else
			low_q <= low_q + 1;
	end
	assign wcmd = cmd_q inside {8'h10, 8'h11, 8'h20, 8'h40, 8'h80};
	assign sig = alo_q == 8'h00 ? SIG0 : (alo_q == 8'h01 ? SIG1 : SIG2);
	// =====================================
	// assertions
	chk_busy_start: assert property (
		$fell(prog_strobe_n) && ready_busy_flag && ser_reset_n && wcmd
		|-> ##[1:3] !ready_busy_flag) else $error("busy did not start");
	chk_busy_len: assert property (
		$rose(ready_busy_flag) && ser_reset_n |->
		low_q >= (cmd_q == 8'h80 ? CE_CYC : WR_CYC) &&
		low_q <= (cmd_q == 8'h80 ? CE_CYC : WR_CYC) + 1)
		else $error("busy window length wrong");
	chk_nop_idle: assert property (
		$fell(prog_strobe_n) && ready_busy_flag && ser_reset_n && !wcmd
		|=> ready_busy_flag [*4]) else $error("busy after non-write");
	chk_ser_ignore: assert property (
		$fell(prog_strobe_n) && ready_busy_flag && !ser_reset_n
		|=> ready_busy_flag [*4]) else $error("strobe acted in serial mode");
	chk_rd_drive: assert property (
		$fell(out_drive_n) && ser_reset_n && cmd_q inside {8'h04, 8'h08}
		|-> ##[1:2] d_data_oe) else $error("read data not driven");
	chk_bus_release: assert property (
		out_drive_n [*3] |-> !d_data_oe) else $error("bus not released");
	chk_oe_cause: assert property (
		$rose(d_data_oe) |-> $past(!out_drive_n) &&
		cmd_q inside {8'h04, 8'h08}) else $error("bus driven unasked");
	chk_sig_read: assert property (
		d_data_oe && $past(d_data_oe) && cmd_q == 8'h08 &&
		!byte_select_primary && alo_q < 8'h03 |-> d_data == sig)
		else $error("identification byte wrong");
	chk_cal_read: assert property (
		d_data_oe && $past(d_data_oe) && cmd_q == 8'h08 &&
		byte_select_primary && alo_q == 8'h00 |-> d_data == CALIB)
		else $error("calibration byte wrong");
	cover property ($rose(ready_busy_flag) && cmd_q == 8'h80);
	cover property ($rose(ready_busy_flag) && cmd_q == 8'h11);
	cover property ($rose(d_data_oe) && cmd_q == 8'h04);
endmodule

// file: dv/ppp_tb.sv
// bench driving the host register port, device joined over the pins
`timescale 1ns/10ps
module ppp_tb;
	localparam int WRC = 20; // shortened self-timed write
	localparam int CEC = 80; // covers the 64-word erase sweep
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic chk = 1'b0; // this read is compared
	logic chk_q = 1'b0; // read data due now
	logic [31:0] rdata;
	logic [7:0] fuse_low;
	logic [7:0] fuse_high;
	logic [7:0] lock_bits;
	logic ser_enabled;
	logic [63:0] notes[$]; // mask over expected value
	logic [63:0] nt;
	logic [7:0] sig[4] = '{8'h5a, 8'h3c, 8'h0f, 8'h80}; // device defaults
	logic [7:0] fz;
	logic [7:0] lk;
	logic [7:0] ee;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	ppp_if pif();
	ppp_host ppp_host_inst (.ref_clk(ref_clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pins(pif.host));
	ppp_device #(.EE_AW(5), .FL_AW(6), .WR_CYC(WRC), .CE_CYC(CEC))
	ppp_device_inst (.ref_clk(ref_clk), .rstn(rstn), .pins(pif.dev),
		.fuse_low(fuse_low), .fuse_high(fuse_high), .lock_bits(lock_bits),
		.ser_enabled(ser_enabled));
	ppp_sva #(.WR_CYC(WRC), .CE_CYC(CEC)) ppp_sva_inst (
		.ref_clk(ref_clk), .rstn(rstn),
		.action_select_high(pif.action_select_high),
		.action_select_low(pif.action_select_low),
		.byte_select_primary(pif.byte_select_primary),
		.load_strobe(pif.load_strobe), .prog_strobe_n(pif.prog_strobe_n),
		.out_drive_n(pif.out_drive_n), .ser_reset_n(pif.ser_reset_n),
		.ready_busy_flag(pif.ready_busy_flag), .d_data(pif.d_data),
		.d_data_oe(pif.d_data_oe), .data(pif.data));
	initial forever #10 ref_clk = ~ref_clk;
	// =====================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	// a noted read leaves its expectation for the watcher
	task automatic rreg(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] v, input logic c);
		@(posedge ref_clk);
		if (c)
			notes.push_back({m, v});
		addr <= a;
		rd <= 1'b1;
		chk <= c;
		@(posedge ref_clk);
		rd <= 1'b0;
		chk <= 1'b0;
	endtask
	// polls until sequencer and serial idle and the device is ready
	task automatic idle();
		int n;
		n = 0;
		do begin
			rreg(ppp_pkg::HR_STAT, 32'h0, 32'h0, 1'b0);
			@(negedge ref_clk);
			n++;
		end while (rdata[2:0] !== 3'b010 && n < 2000);
		if (n >= 2000)
			cyc = 59999; // hang: the watcher counts it and closes the run
	endtask
	task automatic op(input logic [1:0] act, input logic [1:0] bs,
		input logic [7:0] d, input logic [1:0] o);
		wreg(ppp_pkg::HR_PINS, {16'h0, d, 3'h0, 1'b1, bs, act});
		wreg(ppp_pkg::HR_GO, {30'h0, o});
		idle();
	endtask
	task automatic ld(input logic [1:0] act, input logic [1:0] bs,
		input logic [7:0] d);
		op(act, bs, d, ppp_pkg::OP_LOAD);
	endtask
	task automatic pr();
		op(2'h3, 2'h0, 8'h00, ppp_pkg::OP_PROG);
	endtask
	task automatic rdb(input logic [1:0] bs, input logic [7:0] v);
		op(2'h3, bs, 8'h00, ppp_pkg::OP_READ);
		rreg(ppp_pkg::HR_STAT, 32'hff00, {16'h0, v, 8'h00}, 1'b1);
	endtask
	// the second idle catches a busy window that opens late
	task automatic sp(input logic [31:0] f, input logic [31:0] m,
		input logic [31:0] v);
		wreg(ppp_pkg::HR_SPI, f);
		repeat (2) idle();
		rreg(ppp_pkg::HR_SPI, m, v, |m);
	endtask
	// =====================================
	// watcher and hang limit
	always @(posedge ref_clk) begin
		cyc++;
		chk_q <= chk && rd;
		if (chk_q) begin
			nt = notes.pop_front();
			check(rdata & nt[63:32], nt[31:0]);
		end
		if (cyc == 60000) begin
			fails++;
			results();
		end
	end
	// =====================================
	// scenarios
	initial begin
		void'($urandom(9));
		fz = 8'($urandom);
		lk = 8'($urandom) & 8'hfe; // at least one lock programmed
		ee = 8'($urandom) & 8'h7f; // inverse then needs a set bit
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		@(negedge ref_clk);
		check({fuse_low, fuse_high, lock_bits, 7'h0, ser_enabled}, 32'hffffff00);
		ld(ppp_pkg::ACT_CMD, 2'h0, 8'h80);
		pr();
		for (int i = 0; i < 2; i++) begin
			ld(ppp_pkg::ACT_CMD, 2'h0, 8'h40);
			ld(ppp_pkg::ACT_DATA, 2'h0, fz ^ 8'(i));
			op(2'h3, 2'(i), 8'h00, ppp_pkg::OP_PROG);
		end
		check({16'h0, fuse_low, fuse_high}, {16'h0, fz, fz ^ 8'h01});
		ld(ppp_pkg::ACT_CMD, 2'h0, 8'h20);
		ld(ppp_pkg::ACT_DATA, 2'h0, lk);
		pr();
		ld(ppp_pkg::ACT_DATA, 2'h0, 8'hff);
		pr();
		ld(ppp_pkg::ACT_CMD, 2'h0, 8'h00);
		pr();
		ld(ppp_pkg::ACT_CMD, 2'h0, 8'h04);
		rdb(2'h0, fz);
		rdb(2'h3, fz ^ 8'h01);
		rdb(2'h1, lk);
		ld(ppp_pkg::ACT_CMD, 2'h0, 8'h08);
		for (int i = 0; i < 4; i++) begin
			ld(ppp_pkg::ACT_ADDR, 2'h0, 8'(i % 3));
			rdb({1'b0, i == 3}, sig[i]);
		end
		ld(ppp_pkg::ACT_CMD, 2'h0, 8'h11);
		ld(ppp_pkg::ACT_ADDR, 2'h1, 8'h00);
		ld(ppp_pkg::ACT_ADDR, 2'h0, 8'h03);
		ld(ppp_pkg::ACT_DATA, 2'h0, ee);
		op(2'h3, 2'h0, 8'h00, ppp_pkg::OP_PAGE);
		pr();
		wreg(ppp_pkg::HR_PINS, 32'h0);
		wreg(ppp_pkg::HR_GO, {30'h0, ppp_pkg::OP_PROG});
		idle();
		sp({16'hc000, 8'h03, 8'h00}, 32'h0, 32'h0);
		sp(32'hac530000, 32'hff00, 32'h5300);
		check({31'h0, ser_enabled}, 32'h1);
		sp({16'ha000, 8'h03, 8'h00}, 32'hff, {24'h0, ee});
		sp({16'hc000, 8'h03, ~ee}, 32'h0, 32'h0);
		sp({16'ha000, 8'h03, 8'h00}, 32'hff, {24'h0, ~ee});
		ld(ppp_pkg::ACT_CMD, 2'h0, 8'h80);
		pr();
		check({16'h0, lock_bits, fuse_low}, {16'h0, 8'hff, fz});
		wreg(ppp_pkg::HR_PINS, 32'h0);
		sp(32'hac530000, 32'h0, 32'h0);
		sp({16'ha000, 8'h03, 8'h00}, 32'hff, 32'hff);
		results();
	end
endmodule
